// ===== bench/pgm_port_tb.sv
/*
 * Self-checking bench for the general-purpose parallel port.
 * Assumes the slave model on the far side and inputs moved at negedge.
 */
`timescale 1ns/100ps
`default_nettype none

module pgm_port_tb;
   logic              core_clk = 1'b0;
   logic              reset;
   pgm_pkg::pgm_cfg_t cfg;
   logic              req_valid;
   logic              req_ready;
   pgm_pkg::pgm_req_t req;
   logic              rsp_valid;
   logic [29:0]       rsp_data;
   logic              busy;
   logic [29:0]       sig_in;
   logic [29:0]       sig_out;
   logic [29:0]       sig_oe;
   logic              wr_strobe;
   logic              rd_strobe;
   logic              frame;
   logic              iface_clk;
   logic [3:0]        lag;
   logic [29:0]       rd_word;
   logic [29:0]       last_lines;
   logic [29:0]       last_oe;
   int                xfers;
   int                frames;
   int                bad_count = 0;
   int                n_checks = 0;

   always #5 core_clk = ~core_clk;

   pgm_port #(.FIFO_DEPTH(32)) i_dut (.core_clk(core_clk), .reset(reset), .cfg(cfg), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy),
      .sig_in(sig_in), .sig_out(sig_out), .sig_oe(sig_oe), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
      .frame(frame), .iface_clk(iface_clk));

   pgm_slave_model i_far (.core_clk(core_clk), .lag(lag), .rd_word(rd_word), .iface_clk(iface_clk),
      .frame(frame), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .sig_out(sig_out), .sig_oe(sig_oe),
      .sig_in(sig_in), .xfers(xfers), .frames(frames), .last_lines(last_lines), .last_oe(last_oe));

   // =====================================================================
   // helpers
   // =====================================================================
   task automatic check(input string what, input logic [29:0] seen, input logic [29:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up;
      if (bad_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   // own reckoning of which lines carry data and address
   function automatic logic [29:0] lane_map(input logic [1:0] sp, input logic [29:0] d, input logic [19:0] a);
      int          dw;
      logic [59:0] dm;
      logic [59:0] am;
      dw = (sp == 2'h3) ? 30 : 8 * (int'(sp) + 1);
      dm = (60'h1 << dw) - 60'h1;
      am = (sp == 2'h3) ? 60'h0 : (((60'h1 << (28 - dw)) - 60'h1) << dw);
      lane_map = 30'(({30'h0, d} & dm) | (({40'h0, a} << dw) & am));
   endfunction : lane_map

   task automatic set_cfg(input logic [1:0] sp, input logic [4:0] len, input logic [15:0] dv, input logic fr);
      cfg = '{port_operating_mode_field: pgm_pkg::PGM_MODE_GENERAL, split: sp, frame_len: len, baud_div: dv,
              clk_free: fr};
   endtask : set_cfg

   // leaves req_valid high at a negedge once taken
   task automatic push(input logic w, input logic [19:0] a, input logic [29:0] d);
      logic acc;
      int   n;
      req_valid = 1'b1;
      req = {w, a, d};
      n = 0;
      do begin
         acc = req_ready;
         @(negedge core_clk);
         n++;
      end while (!acc && n < 100);
      if (!acc) bad_count++;
   endtask : push

   task automatic wait_xfers(input int n);
      int t;
      t = 0;
      while (xfers < n && t < 3000) begin
         @(negedge core_clk);
         t++;
      end
      check("transfer count", 30'(xfers), 30'(n));
      repeat (12) @(negedge core_clk);
   endtask : wait_xfers

   task automatic count_rises(input int cycles, output int n);
      logic prev;
      n = 0;
      prev = iface_clk;
      repeat (cycles) begin
         @(negedge core_clk);
         if (iface_clk === 1'b1 && prev === 1'b0)
            n++;
         prev = iface_clk;
      end
   endtask : count_rises

   // =====================================================================
   // scenarios
   // =====================================================================
   task automatic t_reset;
      check("ready after reset", 30'(req_ready), 30'h1);
      check("idle frame and clock", {28'h0, frame, iface_clk}, 30'h0);
      check("idle enables", sig_oe, 30'h0);
   endtask : t_reset

   task automatic t_split;
      int base;
      for (int s = 0; s < 4; s++) begin
         set_cfg(2'(s), 5'h01, 16'h0000, 1'b0);
         base = xfers;
         push(1'b1, 20'habcde, 30'h15a5c3e7);
         req_valid = 1'b0;
         wait_xfers(base + 1);
         check("write lines", last_lines, lane_map(2'(s), 30'h15a5c3e7, 20'habcde));
         check("write enables", last_oe, lane_map(2'(s), 30'h3fffffff, 20'hfffff));
      end
   endtask : t_split

   task automatic t_read;
      int t;
      for (int k = 0; k < 2; k++) begin
         set_cfg(2'(k + 1), 5'h01, 16'h0003, 1'b0);
         lag = 4'(3 * k);
         rd_word = 30'h2b3c4d5e;
         push(1'b0, 20'h00a5c, 30'h0);
         req_valid = 1'b0;
         t = 0;
         while (rsp_valid !== 1'b1 && t < 300) begin
            @(negedge core_clk);
            t++;
         end
         check("read answered", 30'(rsp_valid), 30'h1);
         check("read data", rsp_data, lane_map(2'(k + 1), 30'h2b3c4d5e, 20'h0));
         check("read enables", last_oe, lane_map(2'(k + 1), 30'h0, 20'hfffff));
         repeat (20) @(negedge core_clk);
      end
   endtask : t_read

   task automatic t_frames;
      int lens[3] = '{1, 3, 30};
      int cnts[3] = '{3, 5, 31};
      int exps[3] = '{3, 2, 2};
      int b_x;
      int b_f;
      for (int k = 0; k < 3; k++) begin
         set_cfg(2'h3, 5'(lens[k]), 16'h0000, 1'b0);
         b_x = xfers;
         b_f = frames;
         for (int i = 0; i < cnts[k]; i++)
            push(1'b1, 20'h0, 30'(i));
         req_valid = 1'b0;
         wait_xfers(b_x + cnts[k]);
         check("frames per burst", 30'(frames - b_f), 30'(exps[k]));
         // length must not change while a frame is open
         while (frame === 1'b1) @(negedge core_clk);
      end
   endtask : t_frames

   task automatic t_clock;
      int n;
      set_cfg(2'h0, 5'h01, 16'h0000, 1'b1);
      count_rises(40, n);
      check("free clock rises div 0", 30'(n), 30'h14);
      set_cfg(2'h0, 5'h01, 16'h0003, 1'b1);
      repeat (10) @(negedge core_clk);
      count_rises(40, n);
      check("free clock rises div 3", 30'(n), 30'h5);
      check("frame idle when free", 30'(frame), 30'h0);
      n = xfers;
      push(1'b1, 20'h12345, 30'h0000a5);
      req_valid = 1'b0;
      wait_xfers(n + 1);
      check("free write lines", last_lines, lane_map(2'h0, 30'h0000a5, 20'h12345));
      set_cfg(2'h0, 5'h01, 16'h0003, 1'b0);
      repeat (20) @(negedge core_clk);
      count_rises(40, n);
      check("gated idle rises", 30'(n), 30'h0);
      check("busy idle", 30'(busy), 30'h0);
      push(1'b1, 20'h1, 30'h1);
      req_valid = 1'b0;
      @(negedge core_clk);
      check("busy in transfer", 30'(busy), 30'h1);
      count_rises(40, n);
      check("gated clock runs", 30'(n > 0), 30'h1);
      repeat (20) @(negedge core_clk);
   endtask : t_clock

   task automatic t_fill;
      int acc;
      int b_x;
      int b_f;
      set_cfg(2'h3, 5'h1e, 16'h0000, 1'b0);
      cfg.port_operating_mode_field = 4'h1;
      b_x = xfers;
      b_f = frames;
      acc = 0;
      req_valid = 1'b1;
      for (int i = 0; i < 40; i++) begin
         req = {1'b1, 20'h0, 30'(i)};
         acc += int'(req_ready === 1'b1);
         @(negedge core_clk);
      end
      req_valid = 1'b0;
      check("entries taken", 30'(acc), 30'h21);
      check("ready when full", 30'(req_ready), 30'h0);
      repeat (50) @(negedge core_clk);
      check("no traffic off mode", 30'(xfers - b_x + frames - b_f), 30'h0);
      cfg.port_operating_mode_field = pgm_pkg::PGM_MODE_GENERAL;
      wait_xfers(b_x + 33);
      check("frames in drain", 30'(frames - b_f), 30'h2);
      check("ready when drained", 30'(req_ready), 30'h1);
   endtask : t_fill

   // =====================================================================
   // main sequence and watchdog
   // =====================================================================
   initial begin
      reset = 1'b1;
      set_cfg(2'h0, 5'h01, 16'h0000, 1'b0);
      req_valid = 1'b0;
      req = '0;
      lag = 4'h0;
      rd_word = 30'h0;
      repeat (4) @(negedge core_clk);
      reset = 1'b0;
      t_reset;
      t_split;
      t_read;
      t_frames;
      t_clock;
      t_fill;
      wrap_up;
   end

   initial begin
      #300000;
      bad_count++;
      wrap_up;
   end

endmodule : pgm_port_tb

`default_nettype wire

// ===== bench/pgm_slave_model.sv
/*
 * Behavioural slave logic on the far side of the parallel port.
 * Assumes the bench core clock; read data appears lag core cycles
 * after the read strobe rises, so lag must leave setup to the period end.
 */
`timescale 1ns/100ps
`default_nettype none

module pgm_slave_model (
   input  wire logic        core_clk,
   input  wire logic [3:0]  lag,
   input  wire logic [29:0] rd_word,
   input  wire logic        iface_clk,
   input  wire logic        frame,
   input  wire logic        wr_strobe,
   input  wire logic        rd_strobe,
   input  wire logic [29:0] sig_out,
   input  wire logic [29:0] sig_oe,
   output logic      [29:0] sig_in,
   output var int           xfers,
   output var int           frames,
   output logic      [29:0] last_lines,
   output logic      [29:0] last_oe
);
   logic [29:0] noise = 30'h2aaaaaaa;
   logic [3:0]  rd_age = 4'h0;

   initial begin
      xfers = 0;
      frames = 0;
   end

   // =====================================================================
   // line drive
   // =====================================================================
   // undriven lines flip every cycle so a stale value never passes
   always @(posedge core_clk) begin
      noise <= ~noise;
      rd_age <= rd_strobe ? rd_age + 4'h1 : 4'h0;
   end

   always_comb begin
      sig_in = (sig_oe & sig_out) | (~sig_oe & ((rd_strobe && rd_age >= lag) ? rd_word : noise));
   end

   // =====================================================================
   // sampling
   // =====================================================================
   // sample on rising clock
   always @(posedge iface_clk) begin
      if (wr_strobe || rd_strobe) begin
         xfers = xfers + 1;
         last_lines = sig_out;
         last_oe = sig_oe;
      end
   end

   always @(posedge frame) begin
      frames = frames + 1;
   end

endmodule : pgm_slave_model

`default_nettype wire

// ===== rtl/pgm_clkdiv.sv
/*
 * Baud divider that makes the interface clock and the launch pulse.
 * Assumes run is held until a launch with the clock low when gating.
 */
`timescale 1ns/100ps
`default_nettype none

module pgm_clkdiv (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        run,
   input  wire logic [15:0] div,
   output logic             clk_level,
   output logic             launch
);

   logic        started;
   logic [15:0] cnt;
   logic        rise;

   // each half period lasts div+1 core cycles; launch is the falling edge
   assign launch = run & (!started | (clk_level & (cnt == div)));
   assign rise   = run & started & !clk_level & (cnt == div);

   // =====================================================================
   // divider state
   // =====================================================================
   always_ff @(posedge core_clk) begin
      if (reset | !run) begin
         started <= 1'b0;
      end else begin
         started <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset | !run | launch | rise) begin
         cnt <= pgm_pkg::PGM_CNT_RESET;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset | !run) begin
         clk_level <= 1'b0;
      end else if (rise) begin
         clk_level <= 1'b1;
      end else if (launch) begin
         clk_level <= 1'b0;
      end
   end

   property p_half_period;
      @(posedge core_clk) disable iff (reset)
      run && $past(run) && $changed(clk_level) |-> $past(cnt) == $past(div);
   endproperty
   a_half_period: assert property (p_half_period)
      else $error("interface clock half period differs from baud setting");

endmodule : pgm_clkdiv

`default_nettype wire

// ===== rtl/pgm_fifo.sv
/*
 * Request FIFO with a registered, show-ahead output stage.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none

module pgm_fifo #(
   parameter int unsigned WIDTH = 51,
   parameter int unsigned DEPTH = pgm_pkg::PGM_FIFO_DEPTH
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             load;

   assign in_ready = count < (AW+1)'(DEPTH);
   assign push     = in_valid & in_ready;
   // refill the output register when it empties or is taken
   assign load     = (!out_valid | out_ready) & (count != '0);

   // =====================================================================
   // storage
   // =====================================================================
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
         end
         if (load) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         count <= '0;
      end else begin
         count <= count + (AW+1)'(push) - (AW+1)'(load);
      end
   end

   // =====================================================================
   // output register
   // =====================================================================
   always_ff @(posedge core_clk) begin
      if (reset) begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end else if (load) begin
         out_valid <= 1'b1;
         out_data  <= mem[rd_ptr];
      end else if (out_ready) begin
         out_valid <= 1'b0;
      end
   end

endmodule : pgm_fifo

`default_nettype wire

// ===== rtl/pgm_pkg.sv
/*
 * Shared constants, carrier types and pin-packing helpers for the
 * general-purpose clocked parallel port.
 * Assumes a single core clock domain and a synchronous reset.
 */
`default_nettype none

package pgm_pkg;

   // =====================================================================
   // constants
   // =====================================================================
   localparam int unsigned PGM_PINS         = 30;
   localparam int unsigned PGM_ADDR_W       = 20;
   localparam int unsigned PGM_DIV_W        = 16;
   localparam int unsigned PGM_FIFO_DEPTH   = 32;
   localparam logic [3:0]  PGM_MODE_GENERAL = 4'h0;
   localparam logic [4:0]  PGM_FRAME_MIN    = 5'h01;
   localparam logic [4:0]  PGM_FRAME_MAX    = 5'h1e;
   localparam logic [1:0]  PGM_SPLIT_D8     = 2'h0;
   localparam logic [1:0]  PGM_SPLIT_D16    = 2'h1;
   localparam logic [1:0]  PGM_SPLIT_D24    = 2'h2;
   localparam logic [1:0]  PGM_SPLIT_D30    = 2'h3;
   localparam logic [15:0] PGM_CNT_RESET    = 16'h0000;
   localparam logic [4:0]  PGM_LEFT_RESET   = 5'h00;
   localparam logic [29:0] PGM_PINS_RESET   = 30'h00000000;

   // =====================================================================
   // carriers
   // =====================================================================
   typedef struct packed {
      logic        write;
      logic [19:0] addr;
      logic [29:0] data;
   } pgm_req_t;

   typedef struct packed {
      logic [3:0]  port_operating_mode_field;
      logic [1:0]  split;
      logic [4:0]  frame_len;
      logic [15:0] baud_div;
      logic        clk_free;
   } pgm_cfg_t;

   // =====================================================================
   // width split decoding
   // =====================================================================
   function automatic logic [4:0] pgm_data_width(input logic [1:0] split);
      case (split)
         PGM_SPLIT_D8:  pgm_data_width = 5'h08;
         PGM_SPLIT_D16: pgm_data_width = 5'h10;
         PGM_SPLIT_D24: pgm_data_width = 5'h18;
         default:       pgm_data_width = 5'h1e;
      endcase
   endfunction : pgm_data_width

   function automatic logic [29:0] pgm_data_mask(input logic [1:0] split);
      case (split)
         PGM_SPLIT_D8:  pgm_data_mask = 30'h000000ff;
         PGM_SPLIT_D16: pgm_data_mask = 30'h0000ffff;
         PGM_SPLIT_D24: pgm_data_mask = 30'h00ffffff;
         default:       pgm_data_mask = 30'h3fffffff;
      endcase
   endfunction : pgm_data_mask

   function automatic logic [29:0] pgm_addr_mask(input logic [1:0] split);
      case (split)
         PGM_SPLIT_D8:  pgm_addr_mask = 30'h0fffff00;
         PGM_SPLIT_D16: pgm_addr_mask = 30'h0fff0000;
         PGM_SPLIT_D24: pgm_addr_mask = 30'h0f000000;
         default:       pgm_addr_mask = 30'h00000000;
      endcase
   endfunction : pgm_addr_mask

   // data from pin 0 upward, address directly above it
   function automatic logic [29:0] pgm_pack(input logic [1:0]  split,
                                            input logic [29:0] data,
                                            input logic [19:0] addr);
      logic [29:0] wide;
      wide     = {10'h000, addr} << pgm_data_width(split);
      pgm_pack = (data & pgm_data_mask(split)) | (wide & pgm_addr_mask(split));
   endfunction : pgm_pack

endpackage : pgm_pkg

`default_nettype wire

// ===== rtl/pgm_port.sv
/*
 * External parallel port, general-purpose clocked mode: pops queued
 * requests, drives the shared lines, the strobes, frame and the clock.
 * Assumes the slave answers reads on the shared lines within a period.
 */
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - The port runs only while the operating mode field holds zero.
// - A frame output groups consecutive transfers into one frame.
// - Frame length is programmable from 1 to 30 interface clocks.
// - A dedicated interface clock output times each transfer.
// - The interface clock comes from a programmable baud divider.
// - The interface clock runs either gated or free-running.
// - Gated clock toggles only around transfers, marking start and stop.
module pgm_port #(
   parameter int unsigned FIFO_DEPTH = pgm_pkg::PGM_FIFO_DEPTH
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire pgm_pkg::pgm_cfg_t cfg,
   input  wire logic             req_valid,
   output logic                  req_ready,
   input  wire pgm_pkg::pgm_req_t req,
   output logic                  rsp_valid,
   output logic           [29:0] rsp_data,
   output logic                  busy,
   input  wire logic      [29:0] sig_in,
   output logic           [29:0] sig_out,
   output logic           [29:0] sig_oe,
   output logic                  wr_strobe,
   output logic                  rd_strobe,
   output logic                  frame,
   output logic                  iface_clk
);

   typedef enum logic {
      FR_IDLE,
      FR_OPEN
   } pgm_frame_t;

   pgm_frame_t        fstate;
   pgm_pkg::pgm_req_t head;
   logic              q_valid;
   logic              pop;
   logic              mode_ok;
   logic              run;
   logic              launch;
   logic              xfer_on;
   logic [4:0]        left;
   logic [4:0]        len_eff;
   logic [29:0]       sync1;
   logic [29:0]       sync2;

   // =====================================================================
   // request queue
   // =====================================================================
   pgm_fifo #(
      .WIDTH ($bits(pgm_pkg::pgm_req_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .reset     (reset),
      .in_valid  (req_valid),
      .in_ready  (req_ready),
      .in_data   (req),
      .out_valid (q_valid),
      .out_ready (pop),
      .out_data  (head)
   );

   // =====================================================================
   // mode and clocking
   // =====================================================================
   // general mode gate
   assign mode_ok = cfg.port_operating_mode_field == pgm_pkg::PGM_MODE_GENERAL;

   // gated clock runs only while work or a frame is pending
   assign run  = mode_ok & (cfg.clk_free | q_valid | (fstate == FR_OPEN) | xfer_on);
   assign busy = run & !cfg.clk_free;

   pgm_clkdiv u_div (
      .core_clk  (core_clk),
      .reset     (reset),
      .run       (run),
      .div       (cfg.baud_div),
      .clk_level (iface_clk),
      .launch    (launch)
   );

   // clamp length into the legal span
   assign len_eff = (cfg.frame_len < pgm_pkg::PGM_FRAME_MIN) ? pgm_pkg::PGM_FRAME_MIN :
                    (cfg.frame_len > pgm_pkg::PGM_FRAME_MAX) ? pgm_pkg::PGM_FRAME_MAX :
                    cfg.frame_len;

   // no transfer in the period after a frame closes, so frames stay apart
   assign pop = launch & q_valid &
                ((fstate == FR_IDLE) | ((fstate == FR_OPEN) & (left != 5'h00)));

   // =====================================================================
   // framing
   // =====================================================================
   // frame strobe spans len_eff interface clocks
   always_ff @(posedge core_clk) begin
      if (reset | !mode_ok) begin
         fstate <= FR_IDLE;
         frame  <= 1'b0;
         left   <= pgm_pkg::PGM_LEFT_RESET;
      end else if (launch) begin
         case (fstate)
            FR_IDLE: begin
               if (q_valid) begin
                  fstate <= FR_OPEN;
                  frame  <= 1'b1;
                  left   <= len_eff - 5'h01;
               end
            end
            FR_OPEN: begin
               if (left == 5'h00) begin
                  fstate <= FR_IDLE;
                  frame  <= 1'b0;
               end else begin
                  left <= left - 5'h01;
               end
            end
            default: begin
               fstate <= FR_IDLE;
               frame  <= 1'b0;
            end
         endcase
      end
   end

   // =====================================================================
   // transfer strobes and pins
   // =====================================================================
   // drive enables follow the width split
   always_ff @(posedge core_clk) begin
      if (reset | !mode_ok) begin
         wr_strobe <= 1'b0;
         rd_strobe <= 1'b0;
         xfer_on   <= 1'b0;
         sig_oe    <= pgm_pkg::PGM_PINS_RESET;
      end else if (launch) begin
         wr_strobe <= pop & head.write;
         rd_strobe <= pop & !head.write;
         xfer_on   <= pop;
         if (!pop) begin
            sig_oe <= pgm_pkg::PGM_PINS_RESET;
         end else if (head.write) begin
            sig_oe <= pgm_pkg::pgm_data_mask(cfg.split) | pgm_pkg::pgm_addr_mask(cfg.split);
         end else begin
            sig_oe <= pgm_pkg::pgm_addr_mask(cfg.split);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         sig_out <= pgm_pkg::PGM_PINS_RESET;
      end else if (pop) begin
         sig_out <= pgm_pkg::pgm_pack(cfg.split, head.data, head.addr);
      end
   end

   // =====================================================================
   // read return
   // =====================================================================
   always_ff @(posedge core_clk) begin
      if (reset) begin
         sync1 <= pgm_pkg::PGM_PINS_RESET;
         sync2 <= pgm_pkg::PGM_PINS_RESET;
      end else begin
         sync1 <= sig_in;
         sync2 <= sync1;
      end
   end

   // read data taken at the end of its period; synchroniser adds two cycles
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rsp_valid <= 1'b0;
         rsp_data  <= pgm_pkg::PGM_PINS_RESET;
      end else begin
         rsp_valid <= launch & rd_strobe & mode_ok;
         if (launch & rd_strobe) begin
            rsp_data <= sync2 & pgm_pkg::pgm_data_mask(cfg.split);
         end
      end
   end

   // =====================================================================
   // checks
   // =====================================================================
   logic [4:0]  fr_seen;
   logic [16:0] still_cnt;
   logic        clk_prev;

   always_ff @(posedge core_clk) begin
      if (reset | !frame) begin
         fr_seen <= 5'h00;
      end else if (launch) begin
         fr_seen <= fr_seen + 5'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         clk_prev  <= 1'b0;
         still_cnt <= 17'h00000;
      end else begin
         clk_prev  <= iface_clk;
         still_cnt <= (!(cfg.clk_free & mode_ok) | (iface_clk != clk_prev)) ? 17'h00000
                      : still_cnt + 17'h00001;
      end
   end

   property p_mode_off;
      @(posedge core_clk) disable iff (reset)
      !mode_ok |=> !wr_strobe && !rd_strobe && !frame && sig_oe == '0;
   endproperty
   a_mode_off: assert property (p_mode_off)
      else $error("port active outside general mode");

   property p_strobe_in_frame;
      @(posedge core_clk) disable iff (reset)
      wr_strobe || rd_strobe |-> frame;
   endproperty
   a_strobe_in_frame: assert property (p_strobe_in_frame)
      else $error("transfer strobe outside a frame");

   property p_frame_len;
      @(posedge core_clk) disable iff (reset)
      $stable(cfg.frame_len) |-> fr_seen <= len_eff;
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("frame longer than programmed length");

   property p_clk_idle_low;
      @(posedge core_clk) disable iff (reset)
      !run |=> !iface_clk;
   endproperty
   a_clk_idle_low: assert property (p_clk_idle_low)
      else $error("interface clock high while divider stopped");

   property p_free_runs;
      @(posedge core_clk) disable iff (reset)
      cfg.clk_free && mode_ok && $stable(cfg.baud_div) |-> still_cnt <= {1'b0, cfg.baud_div} + 17'h00002;
   endproperty
   a_free_runs: assert property (p_free_runs)
      else $error("free-running interface clock stalled");

   property p_gated_stop;
      @(posedge core_clk) disable iff (reset)
      (mode_ok && !cfg.clk_free && !q_valid && !frame && !xfer_on) [*2] |-> !iface_clk;
   endproperty
   a_gated_stop: assert property (p_gated_stop)
      else $error("gated interface clock toggling without traffic");

   property p_oe_split;
      @(posedge core_clk) disable iff (reset)
      pop |=> sig_oe == (($past(head.write) ? pgm_pkg::pgm_data_mask($past(cfg.split)) : 30'h0)
                         | pgm_pkg::pgm_addr_mask($past(cfg.split)));
   endproperty
   a_oe_split: assert property (p_oe_split)
      else $error("line enables do not match width split");

   property p_pack;
      @(posedge core_clk) disable iff (reset)
      pop |=> (sig_out & pgm_pkg::pgm_data_mask($past(cfg.split)))
              == ($past(head.data) & pgm_pkg::pgm_data_mask($past(cfg.split)));
   endproperty
   a_pack: assert property (p_pack)
      else $error("data not on the lowest lines");

   property p_rsp_masked;
      @(posedge core_clk) disable iff (reset)
      rsp_valid |-> (rsp_data & ~pgm_pkg::pgm_data_mask(cfg.split)) == '0;
   endproperty
   a_rsp_masked: assert property (p_rsp_masked)
      else $error("read data beyond data width");

   c_write: cover property (@(posedge core_clk) disable iff (reset) $rose(wr_strobe));
   c_read:  cover property (@(posedge core_clk) disable iff (reset) rsp_valid);
   c_frame_end: cover property (@(posedge core_clk) disable iff (reset) $fell(frame) && q_valid);
   c_free:  cover property (@(posedge core_clk) disable iff (reset) cfg.clk_free && $rose(iface_clk));

endmodule : pgm_port

`default_nettype wire
